// file: common/readout_pkg.sv
// Types shared by the readout selector files
`default_nettype none
package readout_pkg;
   typedef enum logic {CK_XOR, CK_CRC8} cksum_type_t;

   typedef struct packed {
      logic [1:0] char_table_sel;
      logic addr_step_up;
      logic entry_shift;
      logic two_line;
      logic mux_drive_sel;
      logic [2:0] inversion_sel;
      logic [4:0] frame_rate_sel;
      logic display_on;
      logic cursor_on;
      logic char_blink;
      logic shift_or_move;
      logic move_dir;
      logic screen_cfg;
      logic col_order;
      logic row_order;
      logic icon_only_mode;
      logic icon_flash_on;
      logic pump_enable;
      logic [1:0] pump_multiplier;
      logic [8:0] bias_level_a;
      logic [8:0] bias_level_b;
      logic temp_comp_enable;
      logic temp_filter_on;
      logic temp_measure_enable;
      logic [2:0] comp_slope_a;
      logic [2:0] comp_slope_b;
      logic [2:0] comp_slope_c;
      logic [2:0] comp_slope_d;
      logic clock_out_enable;
   } settings_t;

   typedef struct packed {
      logic valid;
      logic rd;
      logic [1:0] command_class_bits;
      logic [7:0] data;
   } cmd_t;
endpackage
`default_nettype wire

// file: common/readout_regs.svh
// Command codes, field positions and reset values of the readout selector
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH

`define CLASS_CTRL 2'h0
`define SEL_CMD_UPPER 6'h01
`define CLR_FLAG_CMD 8'h1F
`define SEL_CKTYPE_BIT 1
`define SEL_SOURCE_BIT 0
`define CKSUM_RESET 8'h00
`define LAST_STATUS_IDX 4'h9
`define CRC8_POLY 8'h07

`endif

// file: src/status_mux.sv
// Assembles the checksum and nine status bytes and selects one
`default_nettype none
module status_mux (
   // Sources
   input wire readout_pkg::settings_t set_i,
   input wire logic [7:0] cksum_i,
   input wire logic pump_ready_i,
   input wire logic reset_seen_i,
   // Selection
   input wire logic [3:0] idx_i,
   output logic [7:0] byte_o
);
   logic [7:0] st [0:9];
   always_comb begin
      st[0] = cksum_i;
      st[1] = {2'b00, set_i.char_table_sel, set_i.addr_step_up, set_i.entry_shift,
               set_i.two_line, set_i.mux_drive_sel};
      st[2] = {set_i.inversion_sel, set_i.frame_rate_sel};
      st[3] = {set_i.display_on, set_i.cursor_on, set_i.char_blink, set_i.shift_or_move,
               set_i.move_dir, set_i.screen_cfg, set_i.col_order, set_i.row_order};
      st[4] = {1'b0, set_i.icon_only_mode, set_i.icon_flash_on, set_i.pump_enable, 1'b0,
               set_i.pump_multiplier, set_i.bias_level_a[8]};
      st[5] = set_i.bias_level_a[7:0];
      st[6] = {set_i.temp_comp_enable, set_i.temp_filter_on, set_i.comp_slope_a,
               set_i.comp_slope_b};
      st[7] = {set_i.temp_measure_enable, set_i.comp_slope_c, set_i.comp_slope_d,
               set_i.bias_level_b[8]};
      st[8] = set_i.bias_level_b[7:0];
      st[9] = {5'b00000, pump_ready_i, reset_seen_i, set_i.clock_out_enable};
      byte_o = (idx_i <= 4'h9) ? st[idx_i] : 8'h00;
   end
endmodule
`default_nettype wire

// file: src/status_readout_select.sv
// Readout select and status read logic of the display controller
`include "readout_regs.svh"
`default_nettype none
module status_readout_select (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Decoded command bus access
   input wire readout_pkg::cmd_t cmd_i,
   input wire logic rd_next_i,
   // RAM write stream
   input wire logic ram_wr_i,
   input wire logic [7:0] ram_data_i,
   // Mirrored device state
   input wire readout_pkg::settings_t set_i,
   input wire logic [7:0] temp_value_i,
   input wire logic pump_ready_i,
   // Read answer and settings
   output logic [7:0] rd_data_o,
   output logic checksum_type_sel_o,
   output logic status_source_o,
   output logic reset_seen_flag_o
);

   ////////////////////////////////////////////////////////////////////////////////
   logic ck_type_ff;
   logic source_ff;
   logic reset_seen_ff;
   logic [3:0] idx_ff;
   logic [3:0] nxt_idx;
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;
   logic [7:0] cksum;
   logic [7:0] status_byte;
   logic [3:0] sel_idx;
   wire is_ctrl_wr;
   wire sel_cmd;
   wire clr_cmd;
   wire status_rd;

   assign is_ctrl_wr = cmd_i.valid && !cmd_i.rd && (cmd_i.command_class_bits == `CLASS_CTRL);
   assign sel_cmd = is_ctrl_wr && (cmd_i.data[7:2] == `SEL_CMD_UPPER);
   assign clr_cmd = is_ctrl_wr && (cmd_i.data == `CLR_FLAG_CMD);
   assign status_rd = cmd_i.valid && cmd_i.rd && (cmd_i.command_class_bits == `CLASS_CTRL);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ck_type_ff <= 1'b0;
         source_ff <= 1'b0;
      end else if (sel_cmd) begin
         ck_type_ff <= cmd_i.data[`SEL_CKTYPE_BIT];
         source_ff <= cmd_i.data[`SEL_SOURCE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reset_seen_ff <= 1'b1;
      end else if (clr_cmd) begin
         reset_seen_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checksum datapath
   write_checksum u_cksum (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ram_wr_i(ram_wr_i),
      .ram_data_i(ram_data_i),
      .ck_type_i(readout_pkg::cksum_type_t'(ck_type_ff)),
      .cksum_o(cksum)
   );

   status_mux u_mux (
      .set_i(set_i),
      .cksum_i(cksum),
      .pump_ready_i(pump_ready_i),
      .reset_seen_i(reset_seen_ff),
      .idx_i(sel_idx),
      .byte_o(status_byte)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // byte sequencing; stays on status 9 past the end
   assign sel_idx = status_rd ? 4'h0 : idx_ff;
   assign nxt_idx = status_rd ? 4'h1
                  : (rd_next_i && (idx_ff <= `LAST_STATUS_IDX)) ? idx_ff + 4'h1 : idx_ff;
   assign nxt_rd_data = !source_ff ? temp_value_i : status_byte;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         idx_ff <= 4'h0;
         rd_data_ff <= 8'h00;
      end else begin
         idx_ff <= (nxt_idx > `LAST_STATUS_IDX) ? `LAST_STATUS_IDX : nxt_idx;
         if (status_rd || rd_next_i) begin
            rd_data_ff <= nxt_rd_data;
         end
      end
   end

   assign rd_data_o = rd_data_ff;
   assign checksum_type_sel_o = ck_type_ff;
   assign status_source_o = source_ff;
   assign reset_seen_flag_o = reset_seen_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // flag after reset
   chk_flag_after_reset: assert property (@(posedge clk_i) $fell(srst_i) |-> reset_seen_flag_o)
      else $error("reset flag not set after reset");
   chk_flag_clear: assert property (@(posedge clk_i) disable iff (srst_i)
      clr_cmd |=> !reset_seen_flag_o)
      else $error("reset flag not cleared");
   chk_source_sel: assert property (@(posedge clk_i) disable iff (srst_i)
      sel_cmd |=> status_source_o == $past(cmd_i.data[0]))
      else $error("source bit not stored");
   chk_cktype_sel: assert property (@(posedge clk_i) disable iff (srst_i)
      sel_cmd |=> checksum_type_sel_o == $past(cmd_i.data[1]))
      else $error("checksum type not stored");
   chk_first_byte: assert property (@(posedge clk_i) disable iff (srst_i)
      (status_rd && source_ff && !sel_cmd) |=> rd_data_o == $past(cksum))
      else $error("first status byte not checksum");
   chk_temp_read: assert property (@(posedge clk_i) disable iff (srst_i)
      (status_rd && !source_ff) |=> rd_data_o == $past(temp_value_i))
      else $error("temperature not returned");
   chk_cksum_zero: assert property (@(posedge clk_i) $fell(srst_i) |-> cksum == 8'h00)
      else $error("checksum not zero after reset");
   chk_status9_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h9 && !status_rd) |=>
      rd_data_o == {5'h00, $past(pump_ready_i), $past(reset_seen_flag_o),
                    $past(set_i.clock_out_enable)})
      else $error("status 9 layout wrong");
   chk_pump_ready: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h9 && !status_rd) |=> rd_data_o[2] == $past(pump_ready_i))
      else $error("pump ready bit wrong");
   chk_status1_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h1 && !status_rd) |=>
      rd_data_o == {2'b00, $past(set_i.char_table_sel), $past(set_i.addr_step_up),
                    $past(set_i.entry_shift), $past(set_i.two_line),
                    $past(set_i.mux_drive_sel)})
      else $error("status 1 layout wrong");
   chk_status2_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h2 && !status_rd) |=>
      rd_data_o == {$past(set_i.inversion_sel), $past(set_i.frame_rate_sel)})
      else $error("status 2 layout wrong");
   chk_status3_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h3 && !status_rd) |=>
      rd_data_o == {$past(set_i.display_on), $past(set_i.cursor_on), $past(set_i.char_blink),
                    $past(set_i.shift_or_move), $past(set_i.move_dir), $past(set_i.screen_cfg),
                    $past(set_i.col_order), $past(set_i.row_order)})
      else $error("status 3 layout wrong");
   chk_status4_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h4 && !status_rd) |=>
      rd_data_o == {1'b0, $past(set_i.icon_only_mode), $past(set_i.icon_flash_on),
                    $past(set_i.pump_enable), 1'b0, $past(set_i.pump_multiplier),
                    $past(set_i.bias_level_a[8])})
      else $error("status 4 layout wrong");
   chk_status5_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h5 && !status_rd) |=>
      rd_data_o == $past(set_i.bias_level_a[7:0]))
      else $error("status 5 layout wrong");
   chk_status6_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h6 && !status_rd) |=>
      rd_data_o == {$past(set_i.temp_comp_enable), $past(set_i.temp_filter_on),
                    $past(set_i.comp_slope_a), $past(set_i.comp_slope_b)})
      else $error("status 6 layout wrong");
   chk_status7_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h7 && !status_rd) |=>
      rd_data_o == {$past(set_i.temp_measure_enable), $past(set_i.comp_slope_c),
                    $past(set_i.comp_slope_d), $past(set_i.bias_level_b[8])})
      else $error("status 7 layout wrong");
   chk_status8_bits: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && source_ff && idx_ff == 4'h8 && !status_rd) |=>
      rd_data_o == $past(set_i.bias_level_b[7:0]))
      else $error("status 8 layout wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // Independent CRC step, MSB first, no final inversion
   function automatic logic [7:0] crc8_ref(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ({r[6:0], 1'b0} ^ `CRC8_POLY) : {r[6:0], 1'b0};
      end
      return r;
   endfunction

   chk_cktype_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      !sel_cmd |=> $stable(checksum_type_sel_o))
      else $error("checksum type changed without select");
   chk_source_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      !sel_cmd |=> $stable(status_source_o))
      else $error("source changed without select");
   chk_flag_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      !clr_cmd |=> $stable(reset_seen_flag_o))
      else $error("reset flag changed without clear");
   chk_cksum_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      !ram_wr_i |=> $stable(cksum))
      else $error("checksum changed without write");
   chk_cksum_xor: assert property (@(posedge clk_i) disable iff (srst_i)
      (ram_wr_i && !checksum_type_sel_o) |=> cksum == ($past(cksum) ^ $past(ram_data_i)))
      else $error("xor checksum step wrong");
   chk_cksum_crc: assert property (@(posedge clk_i) disable iff (srst_i)
      (ram_wr_i && checksum_type_sel_o) |=>
      cksum == crc8_ref($past(cksum), $past(ram_data_i)))
      else $error("crc checksum step wrong");
   chk_rd_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      (!status_rd && !rd_next_i) |=> $stable(rd_data_o))
      else $error("read data changed without read");
   chk_temp_next: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && !status_rd && !source_ff) |=> rd_data_o == $past(temp_value_i))
      else $error("temperature not repeated");
   chk_idx_restart: assert property (@(posedge clk_i) disable iff (srst_i)
      status_rd |=> idx_ff == 4'h1)
      else $error("index not restarted");
   chk_idx_step: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && !status_rd && idx_ff < 4'h9) |=> idx_ff == $past(idx_ff) + 4'h1)
      else $error("index did not step");
   chk_idx_saturate: assert property (@(posedge clk_i) disable iff (srst_i)
      (rd_next_i && !status_rd && idx_ff == 4'h9) |=> idx_ff == 4'h9)
      else $error("index passed status 9");
   chk_idx_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      (!status_rd && !rd_next_i) |=> $stable(idx_ff))
      else $error("index changed without read");

   ////////////////////////////////////////////////////////////////////////////////
   // reset sets flag
   chk_flag_reset_set: assert property (@(posedge clk_i)
      srst_i |=> reset_seen_flag_o)
      else $error("reset flag not set by reset");
   chk_reset_defaults: assert property (@(posedge clk_i)
      srst_i |=> (!checksum_type_sel_o && !status_source_o &&
                  rd_data_o == 8'h00))
      else $error("settings not default after reset");
   chk_cksum_reset: assert property (@(posedge clk_i)
      srst_i |=> cksum == 8'h00)
      else $error("checksum not cleared by reset");

   cov_status_read: cover property (@(posedge clk_i) status_rd && source_ff);
   cov_temp_read: cover property (@(posedge clk_i) status_rd && !source_ff);
   cov_flag_clear: cover property (@(posedge clk_i) clr_cmd && reset_seen_ff);
   cov_last_byte: cover property (@(posedge clk_i) rd_next_i && idx_ff == 4'h9);
   cov_crc_write: cover property (@(posedge clk_i) ram_wr_i && checksum_type_sel_o);
endmodule
`default_nettype wire

// file: src/write_checksum.sv
// Running checksum over RAM write bytes, XOR or CRC-8
`include "readout_regs.svh"
`default_nettype none
module write_checksum (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Data stream
   input wire logic ram_wr_i,
   input wire logic [7:0] ram_data_i,
   input wire readout_pkg::cksum_type_t ck_type_i,
   // Result
   output logic [7:0] cksum_o
);
   logic [7:0] sum_ff;
   logic [7:0] nxt_sum;

   function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `CRC8_POLY) : (r << 1);
      end
      return r;
   endfunction

   assign nxt_sum = (ck_type_i == readout_pkg::CK_CRC8) ? crc8_step(sum_ff, ram_data_i)
                                                        : (sum_ff ^ ram_data_i);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sum_ff <= `CKSUM_RESET;
      end else if (ram_wr_i) begin
         sum_ff <= nxt_sum;
      end
   end
   assign cksum_o = sum_ff;
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host model issuing commands, status reads and RAM writes
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_i,
   // Command side
   output readout_pkg::cmd_t cmd_o,
   output logic rd_next_o,
   // RAM writes
   output logic ram_wr_o,
   output logic [7:0] ram_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_o = '0;
      rd_next_o = 1'b0;
      ram_wr_o = 1'b0;
      ram_data_o = 8'h00;
   end
   //////////////////////////////////////////////////////////////////
   // one-cycle access
   task automatic access(input logic rd, input logic [1:0] cls, input logic [7:0] d);
      @(negedge clk_i);
      cmd_o = '{1'b1, rd, cls, d};
      @(negedge clk_i);
      // Stale data flipped so nothing leans on it
      cmd_o = '{1'b0, rd, cls, ~d};
   endtask
   task automatic next_byte();
      @(negedge clk_i);
      rd_next_o = 1'b1;
      @(negedge clk_i);
      rd_next_o = 1'b0;
   endtask
   task automatic ram(input logic [7:0] d);
      @(negedge clk_i);
      ram_wr_o = 1'b1;
      ram_data_o = d;
      @(negedge clk_i);
      ram_wr_o = 1'b0;
      ram_data_o = ~d;
   endtask
endmodule
`default_nettype wire

// file: tb/status_readout_select_bench.sv
// Self-checking bench of the readout selector
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin $display("unexpected %s exp %h got %h", nm, ex, gt); err_total++; end end
module status_readout_select_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   readout_pkg::cmd_t cmd;
   logic rd_next, ram_wr, ck_type, source, flag;
   logic pump_ready = 1'b0;
   logic flag_exp = 1'b1;
   logic [7:0] ram_data, rd_data, d;
   logic [7:0] temp = 8'h00;
   logic [7:0] ck_exp = 8'h00;
   readout_pkg::settings_t set = '0;
   logic [63:0] r;
   int seed = 46851;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2 clk_i = ~clk_i;
   host_model u_host (.clk_i(clk_i), .cmd_o(cmd), .rd_next_o(rd_next), .ram_wr_o(ram_wr),
      .ram_data_o(ram_data));
   status_readout_select u_dut (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd),
      .rd_next_i(rd_next), .ram_wr_i(ram_wr), .ram_data_i(ram_data), .set_i(set),
      .temp_value_i(temp), .pump_ready_i(pump_ready), .rd_data_o(rd_data),
      .checksum_type_sel_o(ck_type), .status_source_o(source), .reset_seen_flag_o(flag));
   //////////////////////////////////////////////////////////////////
   function automatic logic [7:0] fold(input logic [7:0] c, input logic [7:0] b, input logic crc);
      logic [7:0] x;
      x = c ^ b;
      if (crc)
         for (int i = 0; i < 8; i++)
            x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction
   function automatic logic [7:0] exp_byte(input int i);
      case (i)
         0: return ck_exp;
         1: return {2'b00, set.char_table_sel, set.addr_step_up, set.entry_shift,
            set.two_line, set.mux_drive_sel};
         2: return {set.inversion_sel, set.frame_rate_sel};
         3: return {set.display_on, set.cursor_on, set.char_blink, set.shift_or_move,
            set.move_dir, set.screen_cfg, set.col_order, set.row_order};
         4: return {1'b0, set.icon_only_mode, set.icon_flash_on, set.pump_enable, 1'b0,
            set.pump_multiplier, set.bias_level_a[8]};
         5: return set.bias_level_a[7:0];
         6: return {set.temp_comp_enable, set.temp_filter_on, set.comp_slope_a, set.comp_slope_b};
         7: return {set.temp_measure_enable, set.comp_slope_c, set.comp_slope_d,
            set.bias_level_b[8]};
         8: return set.bias_level_b[7:0];
         default: return {5'b00000, pump_ready, flag_exp, set.clock_out_enable};
      endcase
   endfunction
   task automatic read_status(input int extra);
      u_host.access(1'b1, 2'b00, 8'h00);
      `CHK("checksum", exp_byte(0), rd_data)
      for (int i = 1; i <= 9 + extra; i++) begin
         u_host.next_byte();
         `CHK("status", exp_byte(i > 9 ? 9 : i), rd_data)
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         results();
      end
   end
   //////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(negedge clk_i);
      srst_i = 1'b0;
      `CHK("defaults", 3'b100, {flag, ck_type, source})
      for (int k = 0; k < 3; k++) begin
         temp = 8'($random(seed));
         u_host.access(1'b1, 2'b00, 8'h00);
         `CHK("temp", temp, rd_data)
         u_host.next_byte();
         `CHK("temp", temp, rd_data)
      end
      $display("test temperature done");
      u_host.access(1'b0, 2'b00, 8'h1F);
      flag_exp = 1'b0;
      `CHK("flag", 1'b0, flag)
      // Near misses must leave settings alone
      u_host.access(1'b0, 2'b01, 8'h07);
      u_host.access(1'b0, 2'b00, 8'h0B);
      `CHK("ignored", 3'b000, {flag, ck_type, source})
      $display("test flag done");
      for (int m = 0; m < 4; m++) begin
         r = {$random(seed), $random(seed)};
         set = readout_pkg::settings_t'(r[$bits(readout_pkg::settings_t)-1:0]);
         pump_ready = r[63];
         temp = r[7:0];
         u_host.access(1'b0, 2'b00, {6'h01, m[1:0]});
         `CHK("mode", m[1:0], {ck_type, source})
         repeat (2 + m) begin
            d = 8'($random(seed));
            u_host.ram(d);
            ck_exp = fold(ck_exp, d, m[1]);
         end
         if (m[0])
            read_status(m == 3 ? 2 : 0);
         else begin
            u_host.access(1'b1, 2'b00, 8'h00);
            `CHK("temp", temp, rd_data)
         end
         $display("test mode %0d done", m);
      end
      @(negedge clk_i);
      srst_i = 1'b1;
      @(negedge clk_i);
      srst_i = 1'b0;
      ck_exp = 8'h00;
      flag_exp = 1'b1;
      `CHK("defaults", 3'b100, {flag, ck_type, source})
      u_host.access(1'b0, 2'b00, 8'h05);
      read_status(0);
      $display("test second reset done");
      results();
   end
endmodule
`default_nettype wire
